//--- design/ipsb_bus_slave.sv
`timescale 1ns/10ps
module ipsb_bus_slave #(
  parameter int unsigned ADDR_W = 4
) (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              nrst_in,
  // Avalon request
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  // Handshake back to master
  output logic                   avs_waitrequest_out,
  // Strobes to register file
  output logic                   rd_stb_out,
  output logic                   wr_stb_out
);

  ipsb_pkg::ipsb_bus_st_t state_ff;
  ipsb_pkg::ipsb_bus_st_t nxt_state;

  // One wait cycle, then accept
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ipsb_pkg::IPSB_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          nxt_state = ipsb_pkg::IPSB_RESP;
        end
      end
      ipsb_pkg::IPSB_RESP: begin
        nxt_state = ipsb_pkg::IPSB_IDLE;
      end
      default: begin
        nxt_state = ipsb_pkg::IPSB_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= ipsb_pkg::IPSB_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Accept strobes in the response cycle
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) &&
                               (state_ff != ipsb_pkg::IPSB_RESP);
  assign rd_stb_out = avs_read_in && (state_ff == ipsb_pkg::IPSB_RESP);
  assign wr_stb_out = avs_write_in && (state_ff == ipsb_pkg::IPSB_RESP);

  a_one_wait_cycle : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("slave did not answer after one wait");

endmodule

//--- design/ipsb_pend_bank.sv
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
module ipsb_pend_bank #(
  parameter int unsigned WIDTH = ipsb_pkg::BANK_WIDTH
) (
  // Clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  nrst_in,
  // Avalon-MM slave
  input  wire logic [3:0]            avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [3:0]            avs_byteenable_in,
  input  wire logic [31:0]           avs_writedata_in,
  output logic [31:0]                avs_readdata_out,
  output logic                       avs_waitrequest_out,
  // Interrupt lines 32..63, their enables and their clears
  input  wire logic [WIDTH-1:0]      irq_src_in,
  input  wire logic [WIDTH-1:0]      irq_enable_in,
  input  wire logic [WIDTH-1:0]      pend_clear_in,
  // Pending state and event interrupt
  output logic [WIDTH-1:0]           pending_force_bits_out,
  output logic                       evt_irq_out
);

  // Only the documented bank width is served
  if (WIDTH != ipsb_pkg::BANK_WIDTH) begin : g_bad_width
    $error("bank width must be 32");
  end

  logic [WIDTH-1:0] pend_ff;
  logic [WIDTH-1:0] nxt_pend;
  logic [2:0]       status_ff;
  logic [2:0]       nxt_status;
  logic [2:0]       mask_ff;
  logic [31:0]      rdata_ff;
  logic [WIDTH-1:0] src_meta_ff;
  logic [WIDTH-1:0] src_sync_ff;
  logic [WIDTH-1:0] en_meta_ff;
  logic [WIDTH-1:0] en_sync_ff;
  logic [WIDTH-1:0] clr_meta_ff;
  logic [WIDTH-1:0] clr_sync_ff;
  logic             rd_stb;
  logic             wr_stb;
  logic [WIDTH-1:0] wr_ones;
  logic [WIDTH-1:0] sw_set;
  logic [WIDTH-1:0] hw_set;
  logic [WIDTH-1:0] clr_bits;
  logic [WIDTH-1:0] dropped;
  logic             wr_force;
  logic             wr_mask;
  logic             rd_status;

  // Expand byte enables to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Address compare
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  // Offsets that hold a register
  function automatic logic mapped(input logic [3:0] a);
    return hit(a, ipsb_pkg::OFS_PEND_FORCE) || hit(a, ipsb_pkg::OFS_PEND_CLEAR) ||
           hit(a, ipsb_pkg::OFS_IRQ_STATUS) || hit(a, ipsb_pkg::OFS_IRQ_MASK);
  endfunction

  ipsb_bus_slave #(
    .ADDR_W (ipsb_pkg::ADDR_WIDTH)
  ) u_bus (
    .sys_clk_in          (sys_clk_in),
    .nrst_in             (nrst_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_waitrequest_out (avs_waitrequest_out),
    .rd_stb_out          (rd_stb),
    .wr_stb_out          (wr_stb)
  );

  // Two-stage synchronisers for outside lines
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_meta_ff <= '0;
      src_sync_ff <= '0;
      en_meta_ff  <= '0;
      en_sync_ff  <= '0;
      clr_meta_ff <= '0;
      clr_sync_ff <= '0;
    end else begin
      src_meta_ff <= irq_src_in;
      src_sync_ff <= src_meta_ff;
      en_meta_ff  <= irq_enable_in;
      en_sync_ff  <= en_meta_ff;
      clr_meta_ff <= pend_clear_in;
      clr_sync_ff <= clr_meta_ff;
    end
  end

  // Decoded strobes for status clear and checks
  assign wr_force  = wr_stb && hit(avs_address_in, ipsb_pkg::OFS_PEND_FORCE);
  assign wr_mask   = wr_stb && hit(avs_address_in, ipsb_pkg::OFS_IRQ_MASK);
  assign rd_status = rd_stb && hit(avs_address_in, ipsb_pkg::OFS_IRQ_STATUS);

  // Set and clear terms
  assign wr_ones  = avs_writedata_in[WIDTH-1:0] & be_mask(avs_byteenable_in);
  assign sw_set   = (wr_stb && hit(avs_address_in, ipsb_pkg::OFS_PEND_FORCE)) ?
                    (wr_ones & en_sync_ff & ~pend_ff) : '0;
  assign dropped  = (wr_stb && hit(avs_address_in, ipsb_pkg::OFS_PEND_FORCE)) ?
                    (wr_ones & ~en_sync_ff) : '0;
  assign hw_set   = src_sync_ff & en_sync_ff & ~pend_ff;
  assign clr_bits = clr_sync_ff |
                    ((wr_stb && hit(avs_address_in, ipsb_pkg::OFS_PEND_CLEAR)) ?
                     wr_ones : '0);

  // Pending next value, clear wins over set when the bit is already pending
  always_comb begin
    nxt_pend = (pend_ff & ~clr_bits) | sw_set | hw_set;
  end

  // Pending register
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_ff <= ipsb_pkg::RST_PEND[WIDTH-1:0];
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // Sticky event status, cleared by read, set wins
  always_comb begin
    nxt_status = status_ff;
    // Clear only what the read returned, so a late event survives
    if (rd_status) begin
      nxt_status = status_ff & ~rdata_ff[2:0];
    end
    if (|sw_set) begin
      nxt_status[ipsb_pkg::EVT_SW_PEND] = 1'b1;
    end
    if (|hw_set) begin
      nxt_status[ipsb_pkg::EVT_HW_PEND] = 1'b1;
    end
    if (|dropped) begin
      nxt_status[ipsb_pkg::EVT_DROPPED] = 1'b1;
    end
  end

  // Status register
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_ff <= ipsb_pkg::RST_STATUS[2:0];
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Mask register
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_ff <= ipsb_pkg::RST_MASK[2:0];
    end else if (wr_stb && hit(avs_address_in, ipsb_pkg::OFS_IRQ_MASK) &&
                 avs_byteenable_in[0]) begin
      mask_ff <= avs_writedata_in[2:0];
    end
  end

  // Read data mux, registered
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_ff <= ipsb_pkg::UNMAPPED_RD;
    end else if (avs_read_in && avs_waitrequest_out) begin
      unique case (avs_address_in)
        ipsb_pkg::OFS_PEND_FORCE: rdata_ff <= pend_ff;
        ipsb_pkg::OFS_PEND_CLEAR: rdata_ff <= pend_ff;
        ipsb_pkg::OFS_IRQ_STATUS: rdata_ff <= {29'h0000_0000, status_ff};
        ipsb_pkg::OFS_IRQ_MASK:   rdata_ff <= {29'h0000_0000, mask_ff};
        default:                  rdata_ff <= ipsb_pkg::UNMAPPED_RD;
      endcase
    end
  end

  assign avs_readdata_out       = rdata_ff;
  assign pending_force_bits_out = pend_ff;
  assign evt_irq_out            = |(status_ff & mask_ff);

  a_write_one_pends : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (wr_stb && avs_address_in == ipsb_pkg::OFS_PEND_FORCE && avs_byteenable_in[0] &&
     avs_writedata_in[0] && en_sync_ff[0] && (!pend_ff[0] || !clr_bits[0])) |=>
    pend_ff[0])
    else $error("write of one did not pend");

  a_disabled_ignored : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (!pend_ff[1] && !en_sync_ff[1]) |=> !pend_ff[1])
    else $error("disabled interrupt became pending");

  a_zero_no_effect : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (!pend_ff[2] && !hw_set[2] && !(wr_stb && avs_address_in ==
     ipsb_pkg::OFS_PEND_FORCE && avs_writedata_in[2])) |=> !pend_ff[2])
    else $error("pending set without cause");

  a_read_shows_pend : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (rd_stb && avs_address_in == ipsb_pkg::OFS_PEND_FORCE) |->
    avs_readdata_out == $past(pend_ff))
    else $error("read data not pending state");

  a_clear_clears : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (clr_bits[3] && !sw_set[3] && !hw_set[3]) |=> !pend_ff[3])
    else $error("clear did not clear pending");

  a_source_sets : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (src_sync_ff[4] && en_sync_ff[4] && (!pend_ff[4] || !clr_bits[4])) |=> pend_ff[4])
    else $error("source line did not set pending");

  a_bit_mapping : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    1'b1 |=> ((pending_force_bits_out & ~$past(pending_force_bits_out)) &
              ~$past(wr_ones | src_sync_ff)) == '0)
    else $error("pending bit set at wrong position");

  a_irq_level : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (|sw_set && mask_ff[ipsb_pkg::EVT_SW_PEND]) |=> evt_irq_out)
    else $error("interrupt not raised");

  a_sw_event_flag : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (|sw_set) |=> status_ff[ipsb_pkg::EVT_SW_PEND])
    else $error("software pend event not flagged");

  a_hw_event_flag : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (|hw_set) |=> status_ff[ipsb_pkg::EVT_HW_PEND])
    else $error("source pend event not flagged");

  a_drop_event_flag : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (|dropped) |=> status_ff[ipsb_pkg::EVT_DROPPED])
    else $error("dropped write not flagged");

  a_status_rd_clear : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (rd_status && avs_readdata_out[ipsb_pkg::EVT_SW_PEND] && !(|sw_set)) |=>
    !status_ff[ipsb_pkg::EVT_SW_PEND])
    else $error("status bit not cleared by read");

  a_late_event_kept : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (rd_status && status_ff[ipsb_pkg::EVT_HW_PEND] &&
     !avs_readdata_out[ipsb_pkg::EVT_HW_PEND]) |=> status_ff[ipsb_pkg::EVT_HW_PEND])
    else $error("unreported event lost on read");

  a_status_sticky : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (status_ff[ipsb_pkg::EVT_DROPPED] && !rd_status) |=> status_ff[ipsb_pkg::EVT_DROPPED])
    else $error("status bit dropped without read");

  a_mask_write_lands : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (wr_mask && avs_byteenable_in[0]) |=> mask_ff == $past(avs_writedata_in[2:0]))
    else $error("mask write did not land");

  a_mask_holds : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !wr_mask |=> $stable(mask_ff))
    else $error("mask changed without write");

  a_pend_stays : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (pend_ff[5] && !clr_bits[5]) |=> pend_ff[5])
    else $error("pending bit lost without clear");

  a_unmapped_zero : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (rd_stb && !mapped(avs_address_in)) |->
    avs_readdata_out == ipsb_pkg::UNMAPPED_RD)
    else $error("unmapped read not zero");

  a_clear_reads_pend : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (rd_stb && hit(avs_address_in, ipsb_pkg::OFS_PEND_CLEAR)) |->
    avs_readdata_out == $past(pend_ff))
    else $error("clear register read not pending state");

  a_unmapped_ignored : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (wr_stb && !mapped(avs_address_in) && !(|clr_bits) && !(|hw_set)) |=>
    ($stable(pend_ff) && $stable(mask_ff)))
    else $error("unmapped write changed state");

  a_irq_drops : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (rd_status && avs_readdata_out[2:0] == status_ff && !(|sw_set) && !(|hw_set) &&
     !(|dropped)) |=>
    !evt_irq_out)
    else $error("interrupt stayed high after status read");

  a_dropped_bit_kept : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (wr_force && avs_byteenable_in[1] && avs_writedata_in[8] && !en_sync_ff[8] &&
     !pend_ff[8]) |=> !pend_ff[8])
    else $error("write to disabled bit pended");

  a_be_gates_write : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (wr_force && !avs_byteenable_in[3] && !pend_ff[31] && !hw_set[31]) |=>
    !pend_ff[31])
    else $error("disabled byte lane was written");

  a_readdata_holds : assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out))
    else $error("read data changed without read");

endmodule

//--- design/ipsb_pkg.sv
package ipsb_pkg;

  // Bank geometry
  localparam int unsigned BANK_WIDTH = 32;
  localparam int unsigned IRQ_BASE   = 32;
  localparam int unsigned ADDR_WIDTH = 4;

  // Register byte offsets
  localparam logic [3:0] OFS_PEND_FORCE = 4'h0;
  localparam logic [3:0] OFS_PEND_CLEAR = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK   = 4'hC;

  // Reset values
  localparam logic [31:0] RST_PEND   = 32'h0000_0000;
  localparam logic [31:0] RST_MASK   = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  // Status event bit positions
  localparam int unsigned EVT_SW_PEND = 0;
  localparam int unsigned EVT_HW_PEND = 1;
  localparam int unsigned EVT_DROPPED = 2;

  // Bus slave states
  typedef enum logic [1:0] {
    IPSB_IDLE = 2'b00,
    IPSB_RESP = 2'b01
  } ipsb_bus_st_t;

endpackage

//--- verification/ipsb_pend_bank_tb.sv
`timescale 1ns/10ps
module ipsb_pend_bank_tb;
  // Bench signals
  logic        clk;
  logic        nrst;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wreq;
  logic [31:0] src;
  logic [31:0] ena;
  logic [31:0] clr;
  logic [31:0] pend;
  logic        evt;
  logic [31:0] rv;
  logic [31:0] acc;
  int          n_mismatch;
  int          num_checks;
  int          cyc;
  localparam int CYC_LIMIT = 2000;

  // Clock source
  always #50 clk = ~clk;

  // Block under test
  ipsb_pend_bank #(.WIDTH(ipsb_pkg::BANK_WIDTH)) DUT (
    .sys_clk_in             (clk),
    .nrst_in                (nrst),
    .avs_address_in         (addr),
    .avs_read_in            (rd),
    .avs_write_in           (wr),
    .avs_byteenable_in      (be),
    .avs_writedata_in       (wdata),
    .avs_readdata_out       (rdata),
    .avs_waitrequest_out    (wreq),
    .irq_src_in             (src),
    .irq_enable_in          (ena),
    .pend_clear_in          (clr),
    .pending_force_bits_out (pend),
    .evt_irq_out            (evt)
  );

  // Verdict and end of run
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compare seen against expected
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Let synchronised inputs settle
  task settle;
    repeat (4) @(posedge clk);
  endtask

  // Test sequence
  task run_tests;
    bus(0, ipsb_pkg::OFS_PEND_FORCE, 0, 0);
    check("pend rst", rv, ipsb_pkg::RST_PEND);
    bus(0, ipsb_pkg::OFS_IRQ_STATUS, 0, 0);
    check("stat rst", rv, ipsb_pkg::RST_STATUS);
    bus(0, ipsb_pkg::OFS_IRQ_MASK, 0, 0);
    check("mask rst", rv, ipsb_pkg::RST_MASK);
    $display("test reset done");
    ena <= '1;
    settle();
    acc = 0;
    for (int n = 0; n < 32; n++) begin
      bus(1, ipsb_pkg::OFS_PEND_FORCE, 32'h1 << n, 4'hF);
      acc[n] = 1'b1;
      check("pend walk", pend, acc);
    end
    bus(1, ipsb_pkg::OFS_PEND_FORCE, 32'h0, 4'hF);
    bus(0, ipsb_pkg::OFS_PEND_FORCE, 0, 0);
    check("pend zero wr", rv, 32'hFFFF_FFFF);
    bus(1, ipsb_pkg::OFS_PEND_CLEAR, 32'h0000_FFFF, 4'hF);
    bus(0, ipsb_pkg::OFS_PEND_CLEAR, 0, 0);
    check("pend local clr", rv, 32'hFFFF_0000);
    clr <= 32'h8000_0000;
    @(posedge clk);
    clr <= 32'h0;
    settle();
    bus(0, ipsb_pkg::OFS_PEND_FORCE, 0, 0);
    check("pend ext clr", rv, 32'h7FFF_0000);
    bus(0, ipsb_pkg::OFS_IRQ_STATUS, 0, 0);
    check("stat sw", rv, 32'h1);
    bus(0, ipsb_pkg::OFS_IRQ_STATUS, 0, 0);
    check("stat rc", rv, 32'h0);
    $display("test set clear done");
    bus(1, ipsb_pkg::OFS_PEND_CLEAR, 32'hFFFF_FFFF, 4'hF);
    ena <= 32'h0000_FFFF;
    settle();
    bus(1, ipsb_pkg::OFS_PEND_FORCE, 32'h0001_0001, 4'hF);
    bus(1, ipsb_pkg::OFS_PEND_FORCE, 32'hFFFF_FFFF, 4'hF);
    check("pend dis", pend, 32'h0000_FFFF);
    bus(0, ipsb_pkg::OFS_IRQ_STATUS, 0, 0);
    check("stat drop", rv, 32'h5);
    bus(1, ipsb_pkg::OFS_PEND_CLEAR, 32'hFFFF_FFFF, 4'hF);
    ena <= 32'hFFFF_FFBF;
    settle();
    bus(1, ipsb_pkg::OFS_PEND_FORCE, 32'hFFFF_FFFF, 4'h2);
    check("pend be", pend, 32'h0000_FF00);
    bus(1, ipsb_pkg::OFS_PEND_CLEAR, 32'hFFFF_FFFF, 4'hF);
    bus(0, ipsb_pkg::OFS_IRQ_STATUS, 0, 0);
    $display("test disabled done");
    src <= 32'h0000_0060;
    settle();
    src <= 32'h0;
    settle();
    check("pend hw", pend, 32'h0000_0020);
    bus(0, ipsb_pkg::OFS_IRQ_STATUS, 0, 0);
    check("stat hw", rv, 32'h2);
    $display("test source done");
    bus(1, ipsb_pkg::OFS_IRQ_MASK, 32'h7, 4'hF);
    check("irq idle", {31'h0, evt}, 32'h0);
    bus(1, ipsb_pkg::OFS_PEND_FORCE, 32'h0000_0080, 4'hF);
    check("irq on", {31'h0, evt}, 32'h1);
    bus(1, ipsb_pkg::OFS_IRQ_MASK, 32'h6, 4'hF);
    check("irq masked", {31'h0, evt}, 32'h0);
    bus(0, ipsb_pkg::OFS_IRQ_MASK, 0, 0);
    check("mask rd", rv, 32'h6);
    bus(1, ipsb_pkg::OFS_IRQ_MASK, 32'h7, 4'hF);
    bus(0, ipsb_pkg::OFS_IRQ_STATUS, 0, 0);
    check("stat irq", rv, 32'h1);
    check("irq clr", {31'h0, evt}, 32'h0);
    $display("test irq done");
    bus(1, 4'h6, 32'hFFFF_FFFF, 4'hF);
    bus(0, 4'h6, 0, 0);
    check("unmapped", rv, ipsb_pkg::UNMAPPED_RD);
    check("pend keep", pend, 32'h0000_00A0);
    $display("test unmapped done");
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    check("pend mid rst", pend, ipsb_pkg::RST_PEND);
    check("irq mid rst", {31'h0, evt}, 32'h0);
    nrst <= 1'b1;
    @(posedge clk);
    bus(0, ipsb_pkg::OFS_IRQ_MASK, 0, 0);
    check("mask mid rst", rv, ipsb_pkg::RST_MASK);
    $display("test mid reset done");
  endtask

  // Reset, then tests raced against the cycle ceiling
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    be = 4'h0;
    wdata = 32'h0;
    src = 32'h0;
    ena = 32'h0;
    clr = 32'h0;
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    fork
      run_tests();
      begin
        while (cyc < CYC_LIMIT) begin
          @(posedge clk);
          cyc++;
        end
        n_mismatch++;
        $display("timeout after %0d cycles", cyc);
      end
    join_any
    complete_run();
  end
endmodule
